// File: sim/pmc_asserts.sv
// Purpose: Port level checks on the power mode controller.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to the controller from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module pmc_asserts (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   // Causes
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic WAKEUP_I,
   input wire logic RESET_PIN_I,
   // Effects
   input wire logic [31:0] RDATA_O,
   input wire logic CORE_CLK_EN_O,
   input wire logic SYS_CLK_EN_O,
   input wire logic LOOP_EN_O,
   input wire logic LOOP_BYPASS_O,
   input wire logic CORE_POWER_O,
   input wire logic PINS_HIZ_O,
   input wire logic DMA_INTERNAL_OK_O,
   input wire logic DMA_EXTERNAL_OK_O,
   input wire logic [15:0] PERIPH_CLK_EN_O,
   input wire logic [11:0] REG_VOLT_MV_O,
   input wire logic BOOT_START_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence leave_hiber_s;
      !CORE_POWER_O ##1 CORE_POWER_O;
   endsequence
   sequence boot_once_s;
      ##[0:1] BOOT_START_O ##1 !BOOT_START_O;
   endsequence
   full_loop_a: assert property (
      CORE_CLK_EN_O && !LOOP_BYPASS_O |-> LOOP_EN_O && SYS_CLK_EN_O)
      else $error("loop or system clock off in full mode");
   light_dma_a: assert property (
      !CORE_CLK_EN_O && SYS_CLK_EN_O |-> DMA_EXTERNAL_OK_O
      && !DMA_INTERNAL_OK_O && LOOP_EN_O)
      else $error("wrong memory reach in light sleep");
   deep_clocks_a: assert property (
      !SYS_CLK_EN_O |-> !CORE_CLK_EN_O && !DMA_EXTERNAL_OK_O
      && !DMA_INTERNAL_OK_O && PERIPH_CLK_EN_O == 16'h0000)
      else $error("clock or dma alive with system clock off");
   deep_hold_a: assert property (
      !SYS_CLK_EN_O && CORE_POWER_O && !RESET_PIN_I |=> !SYS_CLK_EN_O)
      else $error("deep sleep left without reset pin");
   hiber_pins_a: assert property (
      !CORE_POWER_O |-> PINS_HIZ_O && REG_VOLT_MV_O == 12'h000)
      else $error("pins driven or supply up while powered off");
   boot_pulse_a: assert property (
      leave_hiber_s |-> boot_once_s)
      else $error("no single boot pulse after power returns");
   volt_step_a: assert property (
      CORE_POWER_O && REG_VOLT_MV_O != 12'h000 |->
      (REG_VOLT_MV_O - 12'h320) % 12'h032 == 12'h000)
      else $error("regulator voltage off the step grid");
   rdata_idle_a: assert property (
      !$past(RD_I) |-> RDATA_O == 32'h0000_0000)
      else $error("read data outside its cycle");
   mode_hold_a: assert property (
      !WR_I && !$past(WR_I) && !WAKEUP_I && !RESET_PIN_I
      |=> $stable({CORE_CLK_EN_O, SYS_CLK_EN_O, CORE_POWER_O}))
      else $error("mode changed with no cause");
endmodule
`default_nettype wire

// File: sim/pmc_power_mode_controller_test.sv
// Purpose: Self-checking bench for the power mode controller.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes: Expected port patterns follow the mode table.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller_test;
   import pmc_pkg::*;
   localparam logic [5:0] FULL_P = 6'h3B;
   localparam logic [5:0] LIGHT_P = 6'h19;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, d;
   logic wake, pin, boot, ce, se, le, lb, pw, hz, di, de, ren, rby;
   logic [5:0] ratio;
   logic [15:0] periph;
   logic [11:0] volt;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int boots = 0;
   pmc_power_mode_controller dut (.REF_CLK_I(clk), .SYS_RST_I(rst),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .WAKEUP_I(wake), .RESET_PIN_I(pin),
      .CORE_CLK_EN_O(ce), .SYS_CLK_EN_O(se), .LOOP_EN_O(le),
      .LOOP_BYPASS_O(lb), .ACTIVE_RATIO_O(ratio), .CORE_POWER_O(pw),
      .PINS_HIZ_O(hz), .DMA_INTERNAL_OK_O(di), .DMA_EXTERNAL_OK_O(de),
      .PERIPH_CLK_EN_O(periph), .REG_ENABLE_O(ren), .REG_BYPASS_O(rby),
      .REG_VOLT_MV_O(volt), .BOOT_START_O(boot));
   pmc_wake_model wk (.clk_i(clk), .wake_o(wake), .pin_o(pin));
   // ------------------------------------------------------------------
   // Bus tasks and checks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic mode_is(input logic [2:0] m, input logic [5:0] p);
      rd_reg(PMC_MODE_REQ_OFS);
      chk(d, {29'h0, m});
      chk({26'h0, ce, se, pw, hz, di, de}, {26'h0, p});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (boot === 1'b1) boots++;
      if (cycles == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      mode_is(PMC_FULL, FULL_P);
      rd_reg(PMC_STATUS_OFS);
      chk(d, 32'h0000_01D6);
      chk({20'h0, volt}, 32'h0000_04B0);
      rd_reg(8'h20);
      chk(d, 32'h0000_0000);
      wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0007);
      mode_is(PMC_FULL, FULL_P);
      $display("test reset done");
      wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0002);
      mode_is(PMC_REDUCED, FULL_P);
      chk({30'h0, le, lb}, 32'h0000_0003);
      wr_reg(PMC_MULT_CTRL_OFS, 32'h0000_0205);
      chk({25'h0, le, ratio}, 32'h0000_000A);
      wr_reg(PMC_MULT_CTRL_OFS, 32'h0000_0005);
      wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0001);
      chk({26'h0, ratio}, 32'h0000_0005);
      $display("test reduced done");
      for (int s = 0; s < 2; s++) begin
         wr_reg(PMC_MULT_CTRL_OFS, {23'h0, s[0], 8'h05});
         wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0003);
         mode_is(PMC_LIGHT, LIGHT_P);
         wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0001);
         mode_is(PMC_LIGHT, LIGHT_P);
         wk.pulse(1'b0, 3 * s);
         mode_is(s ? PMC_REDUCED : PMC_FULL, FULL_P);
      end
      $display("test light done");
      for (int s = 1; s >= 0; s--) begin
         wr_reg(PMC_MODE_REQ_OFS, 32'h0000_0004);
         wk.pulse(1'b0, 0);
         mode_is(PMC_DEEP, 6'h08);
         wr_reg(PMC_MULT_CTRL_OFS, {23'h0, s[0], 8'h05});
         wk.pulse(1'b1, 2);
         mode_is(s ? PMC_REDUCED : PMC_FULL, FULL_P);
      end
      $display("test deep done");
      wr_reg(PMC_REG_CTRL_OFS, 32'h0000_0031);
      rd_reg(PMC_REG_CTRL_OFS);
      chk(d, 32'h0000_0031);
      chk({20'h0, volt}, 32'h0000_03B6);
      wr_reg(PMC_REG_CTRL_OFS, 32'h0000_0130);
      chk({30'h0, ren, rby}, 32'h0000_0001);
      wr_reg(PMC_PERIPH_EN_OFS, 32'h0000_00F0);
      chk({16'h0, periph}, 32'h0000_00F0);
      $display("test regulator done");
      wr_reg(PMC_REG_CTRL_OFS, 32'h0000_0080);
      mode_is(PMC_HIBER, 6'h04);
      chk({20'h0, volt}, 32'h0000_0000);
      wr_reg(PMC_REG_CTRL_OFS, 32'h0000_0081);
      wk.pulse(1'b1, 0);
      mode_is(PMC_FULL, FULL_P);
      chk(32'(boots), 32'h0000_0001);
      $display("test hibernate done");
      report_and_stop();
   end
endmodule
bind pmc_power_mode_controller pmc_asserts u_chk (
   .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .WR_I(WR_I),
   .RD_I(RD_I), .WAKEUP_I(WAKEUP_I), .RESET_PIN_I(RESET_PIN_I),
   .RDATA_O(RDATA_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
   .SYS_CLK_EN_O(SYS_CLK_EN_O), .LOOP_EN_O(LOOP_EN_O),
   .LOOP_BYPASS_O(LOOP_BYPASS_O), .CORE_POWER_O(CORE_POWER_O),
   .PINS_HIZ_O(PINS_HIZ_O), .DMA_INTERNAL_OK_O(DMA_INTERNAL_OK_O),
   .DMA_EXTERNAL_OK_O(DMA_EXTERNAL_OK_O),
   .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .REG_VOLT_MV_O(REG_VOLT_MV_O),
   .BOOT_START_O(BOOT_START_O));
`default_nettype wire

// File: sim/pmc_wake_model.sv
// Purpose: Wakeup source and reset pin driver beside the controller.
// Assumes: Both lines are synchronous to the controller clock.
// Notes: Each event is a one cycle pulse after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model (
   // Clock
   input wire logic clk_i,
   // Event lines
   output logic wake_o,
   output logic pin_o
);
   initial begin
      wake_o = 1'b0;
      pin_o = 1'b0;
   end
   // Raises one line for a cycle, prompt or after a delay.
   task automatic pulse(input logic use_pin, input int dly);
      repeat (dly) @(posedge clk_i);
      @(posedge clk_i);
      if (use_pin) pin_o <= 1'b1;
      else wake_o <= 1'b1;
      @(posedge clk_i);
      pin_o <= 1'b0;
      wake_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verilog/pmc_pkg.sv
// Purpose: Shared constants and types for the power mode controller.
// Assumes: Registers reached over a plain address/strobe port.
// Notes: Register offsets are byte addresses of 32-bit words.
package pmc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] PMC_MULT_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMC_REG_CTRL_OFS = 8'h04;
   localparam logic [7:0] PMC_MODE_REQ_OFS = 8'h08;
   localparam logic [7:0] PMC_STATUS_OFS = 8'h0C;
   localparam logic [7:0] PMC_PERIPH_EN_OFS = 8'h10;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   // Multiplier loop control: ratio, skip select, loop power down.
   localparam int PMC_RATIO_LSB = 0;
   localparam int PMC_RATIO_W = 6;
   localparam int PMC_SKIP_BIT = 8;
   localparam int PMC_LOOP_OFF_BIT = 9;
   // Regulator control: switch rate, voltage code, bypass.
   localparam int PMC_RATE_LSB = 0;
   localparam int PMC_RATE_W = 2;
   localparam int PMC_VSEL_LSB = 4;
   localparam int PMC_VSEL_W = 4;
   localparam int PMC_VR_BYP_BIT = 8;
   localparam int PMC_PERIPH_N = 16;
   localparam int PMC_VOLT_STEP_MV = 50;
   localparam int PMC_VOLT_BASE_MV = 800;

   // ----------------------------------------------------------------------
   // Reset values and the rate off code
   // ----------------------------------------------------------------------
   localparam logic [5:0] PMC_RATIO_RST = 6'h0A;
   localparam logic [1:0] PMC_RATE_RST = 2'h1;
   localparam logic [3:0] PMC_VSEL_RST = 4'h8;
   localparam logic [1:0] PMC_RATE_OFF = 2'h0;
   localparam logic [15:0] PMC_PERIPH_RST = 16'hFFFF;

   // Software mode requests written to the request register.
   localparam logic [2:0] PMC_REQ_FULL = 3'h1;
   localparam logic [2:0] PMC_REQ_REDUCED = 3'h2;
   localparam logic [2:0] PMC_REQ_LIGHT = 3'h3;
   localparam logic [2:0] PMC_REQ_DEEP = 3'h4;

   typedef enum logic [2:0] {
      PMC_FULL, PMC_REDUCED, PMC_LIGHT, PMC_DEEP, PMC_HIBER
   } pmc_mode_t;

   // Clock and power controls driven to the rest of the chip.
   typedef struct packed {
      logic core_clk_en;
      logic sys_clk_en;
      logic loop_en;
      logic loop_bypass;
      logic core_power;
      logic pins_hiz;
      logic dma_internal_ok;
      logic dma_external_ok;
   } pmc_ctl_t;

   // Register port command bundle.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pmc_bus_t;

endpackage

// File: verilog/pmc_power_mode_controller.sv
// Purpose: Power mode sequencer with clock, DMA and regulator control.
// Assumes: Wakeup and reset pin inputs are synchronous to REF_CLK_I.
// Notes: Reads return data one cycle after the read strobe.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module pmc_power_mode_controller
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Wakeup sources
   input wire logic WAKEUP_I,
   input wire logic RESET_PIN_I,
   // Clock and power controls
   output logic CORE_CLK_EN_O,
   output logic SYS_CLK_EN_O,
   output logic LOOP_EN_O,
   output logic LOOP_BYPASS_O,
   output logic [5:0] ACTIVE_RATIO_O,
   output logic CORE_POWER_O,
   output logic PINS_HIZ_O,
   output logic DMA_INTERNAL_OK_O,
   output logic DMA_EXTERNAL_OK_O,
   output logic [PMC_PERIPH_N-1:0] PERIPH_CLK_EN_O,
   // Regulator controls and boot start
   output logic REG_ENABLE_O,
   output logic REG_BYPASS_O,
   output logic [11:0] REG_VOLT_MV_O,
   output logic BOOT_START_O
);

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------
   pmc_bus_t bus;
   pmc_mode_t mode;
   pmc_mode_t next_mode;
   pmc_ctl_t ctl;
   logic [5:0] ratio;
   logic [5:0] active_ratio;
   logic skip_sel;
   logic loop_off;
   logic [1:0] rate;
   logic [3:0] vsel;
   logic vr_bypass;
   logic [PMC_PERIPH_N-1:0] periph_en;
   logic [2:0] mode_req;
   logic req_valid;

   assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

   function automatic logic hit(input pmc_bus_t b, input logic [7:0] ofs);
      hit = b.wr && (b.addr == ofs);
   endfunction

   // Skip select picks the mode that a wakeup from light or deep sleep resumes in.
   function automatic pmc_mode_t wake_target(input logic skip);
      wake_target = skip ? PMC_REDUCED : PMC_FULL;
   endfunction

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ratio <= PMC_RATIO_RST;
         skip_sel <= 1'b0;
         loop_off <= 1'b0;
      end else if (hit(bus, PMC_MULT_CTRL_OFS)) begin
         ratio <= bus.wdata[PMC_RATIO_LSB +: PMC_RATIO_W];
         skip_sel <= bus.wdata[PMC_SKIP_BIT];
         loop_off <= bus.wdata[PMC_LOOP_OFF_BIT];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         rate <= PMC_RATE_RST;
         vsel <= PMC_VSEL_RST;
         vr_bypass <= 1'b0;
      end else if (hit(bus, PMC_REG_CTRL_OFS)) begin
         rate <= bus.wdata[PMC_RATE_LSB +: PMC_RATE_W];
         vsel <= bus.wdata[PMC_VSEL_LSB +: PMC_VSEL_W];
         vr_bypass <= bus.wdata[PMC_VR_BYP_BIT];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         periph_en <= PMC_PERIPH_RST;
      end else if (hit(bus, PMC_PERIPH_EN_OFS)) begin
         periph_en <= bus.wdata[PMC_PERIPH_N-1:0];
      end
   end

   // Codes other than the four requests fall through and leave the mode.
   assign req_valid = hit(bus, PMC_MODE_REQ_OFS);
   assign mode_req = bus.wdata[2:0];

   // Read data stand for one cycle only and are zero otherwise.
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= 32'h0000_0000;
      end else if (bus.rd) begin
         unique case (bus.addr)
            PMC_MULT_CTRL_OFS:
               RDATA_O <= {22'h00_0000, loop_off, skip_sel, 2'h0, ratio};
            PMC_REG_CTRL_OFS:
               RDATA_O <= {23'h00_0000, vr_bypass, vsel, 2'h0, rate};
            PMC_STATUS_OFS:
               RDATA_O <= {23'h00_0000, ctl, 1'b0};
            PMC_PERIPH_EN_OFS:
               RDATA_O <= {16'h0000, periph_en};
            PMC_MODE_REQ_OFS:
               RDATA_O <= {29'h0000_0000, mode};
            default:
               RDATA_O <= 32'h0000_0000;
         endcase
      end else begin
         RDATA_O <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------------
   // Mode changes only on cause
   always_comb begin
      next_mode = mode;
      unique case (mode)
         PMC_FULL, PMC_REDUCED: begin
            if (req_valid) begin
               unique case (mode_req)
                  PMC_REQ_FULL: next_mode = PMC_FULL;
                  PMC_REQ_REDUCED: next_mode = PMC_REDUCED;
                  PMC_REQ_LIGHT: next_mode = PMC_LIGHT;
                  PMC_REQ_DEEP: next_mode = PMC_DEEP;
                  default: next_mode = mode;
               endcase
            end
         end
         PMC_LIGHT: begin
            // The reset pin wakes light sleep as well as the wakeup line.
            // Wakeup samples skip select
            if (WAKEUP_I || RESET_PIN_I) begin
               next_mode = wake_target(skip_sel);
            end
         end
         PMC_DEEP: begin
            if (RESET_PIN_I) begin
               next_mode = wake_target(skip_sel);
            end
         end
         PMC_HIBER: begin
            if (RESET_PIN_I) begin
               next_mode = PMC_FULL;
            end
         end
      endcase
      // A rate left at zero drops the block straight back into hibernate,
      // so software restores a nonzero rate before pulsing the reset pin.
      // Rate zero enters hibernate
      if (mode != PMC_HIBER && rate == PMC_RATE_OFF && !vr_bypass) begin
         next_mode = PMC_HIBER;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         mode <= PMC_FULL;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         BOOT_START_O <= 1'b0;
      end else begin
         BOOT_START_O <= (mode == PMC_HIBER) && (next_mode != PMC_HIBER);
      end
   end

   // The ratio register may change freely in reduced mode; only the copy
   // taken in each cycle whose next mode is full ever reaches the loop.
   // Ratio realised in full mode
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         active_ratio <= PMC_RATIO_RST;
      end else if (next_mode == PMC_FULL) begin
         active_ratio <= ratio;
      end
   end

   // ----------------------------------------------------------------------
   // Per-mode controls
   // ----------------------------------------------------------------------
   always_comb begin
      ctl = '0;
      unique case (mode)
         PMC_FULL: begin
            ctl.core_clk_en = 1'b1;
            ctl.sys_clk_en = 1'b1;
            ctl.loop_en = 1'b1;
            ctl.core_power = 1'b1;
            ctl.dma_internal_ok = 1'b1;
            ctl.dma_external_ok = 1'b1;
         end
         PMC_REDUCED: begin
            ctl.core_clk_en = 1'b1;
            ctl.sys_clk_en = 1'b1;
            ctl.loop_en = !loop_off;
            ctl.loop_bypass = 1'b1;
            ctl.core_power = 1'b1;
            ctl.dma_internal_ok = 1'b1;
            ctl.dma_external_ok = 1'b1;
         end
         PMC_LIGHT: begin
            ctl.sys_clk_en = 1'b1;
            ctl.loop_en = 1'b1;
            ctl.core_power = 1'b1;
            ctl.dma_external_ok = 1'b1;
         end
         PMC_DEEP: begin
            ctl.core_power = 1'b1;
         end
         PMC_HIBER: begin
            ctl.pins_hiz = 1'b1;
         end
      endcase
   end

   // The supply code follows next_mode, so it reads zero in the very cycle
   // in which the mode register first shows hibernate.
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         REG_VOLT_MV_O <= 12'h000;
      end else begin
         REG_VOLT_MV_O <= (next_mode == PMC_HIBER) ? 12'h000 :
            12'(PMC_VOLT_BASE_MV + PMC_VOLT_STEP_MV * int'(vsel));
      end
   end

   assign CORE_CLK_EN_O = ctl.core_clk_en;
   assign SYS_CLK_EN_O = ctl.sys_clk_en;
   assign LOOP_EN_O = ctl.loop_en;
   assign LOOP_BYPASS_O = ctl.loop_bypass;
   assign ACTIVE_RATIO_O = active_ratio;
   assign CORE_POWER_O = ctl.core_power;
   assign PINS_HIZ_O = ctl.pins_hiz;
   assign DMA_INTERNAL_OK_O = ctl.dma_internal_ok;
   assign DMA_EXTERNAL_OK_O = ctl.dma_external_ok;
   for (genvar i = 0; i < PMC_PERIPH_N; i++) begin : g_gate
      assign PERIPH_CLK_EN_O[i] = ctl.sys_clk_en && periph_en[i];
   end
   assign REG_ENABLE_O = (mode != PMC_HIBER) && !vr_bypass;
   assign REG_BYPASS_O = vr_bypass;

endmodule

`default_nettype wire
